// ==== bench/msps_core_bench.sv ====
// self-checking bench of the poll sequencer
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; $display("mismatch %s exp %h got %h", n, e, g); end end
`define A(n) {2'h0, msps_pkg::n, 2'h0}
module msps_core_bench;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic thermal_warning = 1'b0, pready, pslverr, irq_n, switch_change_flag;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic [23:0] closed = 24'h000000, mask = 24'h000000, seen_ff, all_ff, wet_q, wet_on, sense_cmp;
	logic [35:0] mclosed = 36'h0_0000_0000;
	logic [71:0] wet_code;
	logic [9:0] adc_value, cmp_level;
	logic [4:0] adc_sel;
	int err_total = 0, checks = 0, cyc_ff = 0, idle_ff = 0, bnd_ff = 0;

	always #5 pclk = ~pclk;

	// short active and poll times keep each cycle a few thousand clocks
	msps_core #(.ACT_US(2), .POLL_US(5)) msps_core_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sense_cmp(sense_cmp),
		.adc_value(adc_value), .thermal_warning(thermal_warning), .wet_on(wet_on),
		.wet_code(wet_code), .adc_sel(adc_sel), .cmp_level(cmp_level), .irq_n(irq_n),
		.switch_change_flag(switch_change_flag));
	msps_switches msps_switches_i (.wet_on(wet_on), .adc_sel(adc_sel), .closed(closed),
		.mclosed(mclosed), .sense_cmp(sense_cmp), .adc_value(adc_value));

	// long all-off stretch marks a cycle boundary; standard steps must follow the whole matrix
	always @(posedge pclk) begin
		cyc_ff <= cyc_ff + 1;
		wet_q <= wet_on;
		idle_ff <= (wet_on == 24'h000000) ? idle_ff + 1 : 0;
		if (!presetn || idle_ff == 300) begin
			seen_ff <= 24'h000000;
			bnd_ff <= bnd_ff + 1;
		end else begin
			seen_ff <= seen_ff | (wet_on & mask);
		end
		all_ff <= presetn ? (all_ff | wet_on) : 24'h000000;
		if (presetn && mask != 0 && |(wet_on & ~wet_q & ~mask)) `CHK("order", mask, seen_ff & mask)
		if (cyc_ff == 98000) begin
			err_total++;
			final_report;
		end
	end

	task automatic final_report;
		$display("errors %0d checks %0d", err_total, checks);
		if (err_total == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic rst;
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		`CHK("prdata", x, q)
		`CHK("pslverr", xe, e)
	endtask

	// bounded waits on design outputs; wbnd waits unbounded for cycle boundaries
	task automatic wcode(input int i, input logic [2:0] x);
		int n;
		n = 0;
		while (wet_code[3 * i +: 3] !== x && n < 20000) begin
			@(posedge pclk);
			n++;
		end
		`CHK("wet_code", x, wet_code[3 * i +: 3])
	endtask

	task automatic won(input logic [23:0] x);
		int n;
		n = 0;
		while (wet_on !== x && n < 20000) begin
			@(posedge pclk);
			n++;
		end
		`CHK("wet_on", x, wet_on)
	endtask

	task automatic wirq;
		int n;
		n = 0;
		while (irq_n !== 1'b0 && n < 30000) begin
			@(posedge pclk);
			n++;
		end
		`CHK("irq_n", 1'b0, irq_n)
	endtask

	task automatic wbnd(input int k);
		int b;
		b = bnd_ff;
		while (bnd_ff < b + k) @(posedge pclk);
	endtask

	task automatic t_regs;
		rst;
		rd(`A(IDX_CTRL), 32'h0000_0000, 1'b0);
		rd(msps_pkg::OFF_IRQ, 32'h0000_0000, 1'b0);
		wr(`A(IDX_LCMP), 32'h0000_0155);
		rd(`A(IDX_LCMP), 32'h0000_0155, 1'b0);
		`CHK("cmp_level", 10'h155, cmp_level)
		wr(msps_pkg::OFF_MLO, 32'hFFFF_FFFF);
		rd(msps_pkg::OFF_MLO, 32'h0000_0000, 1'b0);
		rd(8'h50, 32'h0000_0000, 1'b1);
		`CHK("irq_n", 1'b1, irq_n)
	endtask

	// matrix contact sink 0 / source 0 closed; only input 0 and spares enabled
	task automatic t_matrix(input logic [1:0] sel, input logic [23:0] mm, input logic [23:0] sp);
		rst;
		mclosed <= 36'h0_0000_0001;
		wr(`A(IDX_EN), {8'h00, 24'h000001 | sp});
		wr(`A(IDX_ROLE), 32'h0000_FC00);
		wr(`A(IDX_WCA), 32'h1B6D_B002);
		wr(`A(IDX_WCB), 32'h0000_9249);
		wr(`A(IDX_IRQB), 32'h0000_FC00);
		mask <= mm;
		wr(`A(IDX_CTRL), {28'h0000000, sel, sel == 2'h1, 1'b1});
		wirq;
		`CHK("flag", 1'b1, switch_change_flag)
		`CHK("polled", 24'h000001 | sp | mm, all_ff)
		if (sel == 2'h3) begin
			rd(msps_pkg::OFF_MLO, 32'hFFFF_FFFE, 1'b0);
			rd(msps_pkg::OFF_MHI, 32'h0000_000F, 1'b0);
		end
		rd(msps_pkg::OFF_IRQ, 32'h0000_0001, 1'b0);
		`CHK("irq_n", 1'b1, irq_n)
		if (sel == 2'h3) begin
			wbnd(2);
			`CHK("irq_n", 1'b1, irq_n)
			mclosed <= 36'h0_0000_0081;
			wirq;
			rd(msps_pkg::OFF_MLO, 32'hFFFF_FF7E, 1'b0);
			rd(msps_pkg::OFF_IRQ, 32'h0000_0001, 1'b0);
		end
		mask <= 24'h000000;
		mclosed <= 36'h0_0000_0000;
	endtask

	task automatic t_clean;
		rst;
		wr(`A(IDX_EN), 32'h0000_0007);
		wr(`A(IDX_CLCFG), 32'h0000_0104);
		wr(`A(IDX_CLMSK), 32'h0000_0002);
		wr(`A(IDX_CTRL), 32'h0000_0041);
		wirq;
		rd(msps_pkg::OFF_IRQ, 32'h0000_0001, 1'b0);
		won(24'h000005);
		`CHK("clean_cur", msps_pkg::CUR_10MA, wet_code[8:6])
		won(24'h000002);
		`CHK("adc_sel", 5'h01, adc_sel)
		wbnd(2);
		`CHK("irq_n", 1'b1, irq_n)
	endtask

	// continuous mode, input 0 at 10 mA and input 1 at 15 mA, both sinks
	task automatic t_scale;
		rst;
		wr(`A(IDX_EN), 32'h0000_0003);
		wr(`A(IDX_WCA), 32'h0000_002C);
		wr(`A(IDX_CTRL), 32'h0000_0013);
		wirq;
		`CHK("cur0", msps_pkg::CUR_10MA, wet_code[2:0])
		closed <= 24'h000001;
		wcode(0, msps_pkg::CUR_2MA);
		`CHK("cur1", msps_pkg::CUR_15MA, wet_code[5:3])
		closed <= 24'h000000;
		wcode(0, msps_pkg::CUR_10MA);
		thermal_warning <= 1'b1;
		wcode(1, msps_pkg::CUR_2MA);
		wr(`A(IDX_CTRL), 32'h0000_0193);
		wcode(1, msps_pkg::CUR_15MA);
		thermal_warning <= 1'b0;
		// input 0 on the converter path, mapped level between open and closed readings
		wr(`A(IDX_LMAP), 32'h0000_0200);
		wr(`A(IDX_MODE), 32'h0000_0001);
		closed <= 24'h000001;
		wcode(0, msps_pkg::CUR_2MA);
		closed <= 24'h000000;
		wcode(0, msps_pkg::CUR_10MA);
		wr(`A(IDX_WCB), 32'hC000_0000);
		closed <= 24'h000001;
		repeat (3000) @(posedge pclk);
		`CHK("cur0", msps_pkg::CUR_10MA, wet_code[2:0])
	endtask

	initial begin
		t_regs;
		t_matrix(2'h3, 24'h00FFF0, 24'h000000);
		t_matrix(2'h2, 24'h007DF0, 24'h008200);
		t_matrix(2'h1, 24'h003CF0, 24'h00C300);
		t_clean;
		t_scale;
		final_report;
	end
endmodule // msps_core_bench

// ==== bench/msps_switches.sv ====
// behavioural switch field: direct switches to ground plus a sink/source matrix
`timescale 1ns/1ns
module msps_switches (
	input wire logic [23:0] wet_on,
	input wire logic [4:0] adc_sel,
	input wire logic [23:0] closed,
	input wire logic [35:0] mclosed,
	output logic [23:0] sense_cmp,
	output logic [9:0] adc_value
);
	// pull-up holds an open line high; a matrix contact only pulls its source low while its sink runs
	always_comb begin
		sense_cmp = ~closed;
		for (int i = 0; i < 6; i++) begin
			for (int j = 0; j < 6; j++) begin
				if (wet_on[4 + i] && mclosed[i * 6 + j]) begin
					sense_cmp[10 + j] = 1'b0;
				end
			end
		end
	end
	// converter reads low on a closed contact
	assign adc_value = (adc_sel < 5'h18 && closed[adc_sel]) ? 10'h010 : 10'h3F0;
endmodule // msps_switches

// ==== rtl/msps_core.sv ====
// matrix switch poll sequencer with apb register file
// Contract
// - matrix group polled before standard inputs
// - matrix results stored, used as baseline
// - full cycle end raises flag and irq
// - reading irq status clears it
// - first cycle always interrupts, later on change
// - thermal warning cuts 10/15mA to 2mA
// - matrix compares on sources, their irq enables
// - matrix inputs always enabled, three sizes
// - debounce filter bypassed for matrix inputs
// - no continuous mode while matrix selected
// - 5x5 and 4x4 spare inputs polled standard
// - cleaning step on all after delay
// - cleaning never affects interrupts
// - cleaning current, duration, mask from registers
// - closed switch scales 10/15mA to 2mA
// - closure by comparator or converter level
// - converter level chosen by input number
// - debounce delays current reduction
// - current restored after debounce on open
// - scaling only high settings, continuous mode
`timescale 1ns/1ns
module msps_core #(
	parameter int ACT_US = msps_pkg::ACT_US_DEF,
	parameter int POLL_US = msps_pkg::POLL_US_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [23:0] sense_cmp,
	input wire logic [9:0] adc_value,
	input wire logic thermal_warning,
	output logic [23:0] wet_on,
	output logic [71:0] wet_code,
	output logic [4:0] adc_sel,
	output logic [9:0] cmp_level,
	output logic irq_n,
	output logic switch_change_flag
);
	logic [31:0] cfg_ff [16];
	logic [23:0] sense_s;
	logic [9:0] adc_s;
	logic tw_s;
	msps_pkg::msps_state_e st_ff;
	logic [4:0] idx_ff;
	logic [2:0] si_ff;
	logic [2:0] sj_ff;
	logic [15:0] tmr_ff;
	logic [6:0] us_cnt_ff;
	logic [23:0] status_ff;
	logic [35:0] mstate_ff;
	logic [35:0] mnew_ff;
	logic flag_ff;
	logic first_ff;
	logic done_ff;
	logic [23:0] wet_on_ff;
	logic [71:0] wet_code_ff;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_rdata;

	// size of the matrix group, zero when none is selected
	function automatic logic [2:0] mtx_n(input logic [1:0] sel);
		case (sel)
			msps_pkg::MTX_NONE: mtx_n = 3'h0;
			msps_pkg::MTX_4: mtx_n = 3'h4;
			msps_pkg::MTX_5: mtx_n = 3'h5;
			default: mtx_n = 3'h6;
		endcase
	endfunction

	// first standard input at or after start, 24 when none is left
	function automatic logic [4:0] first_from(input logic [4:0] start, input logic [23:0] m);
		first_from = 5'h18;
		for (int i = 23; i >= 0; i--) begin
			if (m[i] && (5'(i) >= start)) begin
				first_from = 5'(i);
			end
		end
	endfunction

	// converter closure level by input number
	function automatic logic [9:0] lvl_for(input logic [4:0] i, input logic [9:0] l0,
			input logic [9:0] l1, input logic [9:0] l2, input logic [9:0] l3);
		if (i <= 5'h0B) begin
			lvl_for = l0;
		end else if (i <= 5'h11) begin
			lvl_for = l1;
		end else if (i <= 5'h16) begin
			lvl_for = l2;
		end else begin
			lvl_for = l3;
		end
	endfunction

	// pin inputs cross into pclk before any use
	msps_sync #(.W(24)) u_sync_sense (.clk(pclk), .rst_n(presetn), .d(sense_cmp), .q(sense_s));
	msps_sync #(.W(10)) u_sync_adc (.clk(pclk), .rst_n(presetn), .d(adc_value), .q(adc_s));
	msps_sync #(.W(1)) u_sync_tw (.clk(pclk), .rst_n(presetn), .d(thermal_warning), .q(tw_s));

	// apb decode, zero wait states
	wire apb_acc = psel && penable;
	wire apb_wr = apb_acc && pwrite;
	wire apb_rd = apb_acc && !pwrite;
	wire [3:0] ridx = paddr[5:2];
	wire cfg_hit = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0);
	wire ro_hit = (paddr == msps_pkg::OFF_STAT) || (paddr == msps_pkg::OFF_MLO) ||
		(paddr == msps_pkg::OFF_MHI) || (paddr == msps_pkg::OFF_IRQ);
	wire irq_rd = apb_rd && (paddr == msps_pkg::OFF_IRQ);
	wire cfg_wr = apb_wr && cfg_hit;
	assign pready = 1'b1;
	assign pslverr = apb_acc && !cfg_hit && !ro_hit;

	// control fields
	wire [31:0] ctrl = cfg_ff[msps_pkg::IDX_CTRL];
	wire run = ctrl[msps_pkg::CTRL_TRIG];
	wire [1:0] msel = ctrl[msps_pkg::CTRL_MTX +: 2];
	wire [1:0] deb = ctrl[msps_pkg::CTRL_DEB +: 2];
	wire clean_en = ctrl[msps_pkg::CTRL_CLEAN];
	wire [2:0] n_m = mtx_n(msel);
	wire cont_mode = ctrl[msps_pkg::CTRL_CONT] && (msel == msps_pkg::MTX_NONE);
	wire trig_wr = cfg_wr && (ridx == msps_pkg::IDX_CTRL) && pwdata[msps_pkg::CTRL_TRIG] && !run;
	wire [23:0] role = cfg_ff[msps_pkg::IDX_ROLE][23:0];
	wire [23:0] conv = cfg_ff[msps_pkg::IDX_MODE][23:0];
	wire [31:0] wcb = cfg_ff[msps_pkg::IDX_WCB];

	// matrix membership: sinks from input 4, sources from input 10
	logic [23:0] mtx_mask;
	always_comb begin
		mtx_mask = 24'h00_0000;
		for (int k = 0; k < 6; k++) begin
			if (3'(k) < n_m) begin
				mtx_mask[4 + k] = 1'b1;
				mtx_mask[10 + k] = 1'b1;
			end
		end
	end
	wire [23:0] eff_en = cfg_ff[msps_pkg::IDX_EN][23:0] | mtx_mask;
	wire [23:0] std_mask = eff_en & ~mtx_mask;
	wire [4:0] std_first = first_from(5'h00, std_mask);
	wire [4:0] std_next = first_from(idx_ff + 5'h01, std_mask);

	// register writes in the access phase, read data capture in the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 16; i++) begin
				cfg_ff[i] <= msps_pkg::RST_CFG;
			end
			prdata_ff <= 32'h0000_0000;
		end else begin
			if (cfg_wr) begin
				cfg_ff[ridx] <= pwdata;
			end
			if (psel && !penable) begin
				prdata_ff <= nxt_rdata;
			end
		end
	end
	always_comb begin
		if (cfg_hit) begin
			nxt_rdata = cfg_ff[ridx];
		end else if (paddr == msps_pkg::OFF_STAT) begin
			nxt_rdata = {8'h00, status_ff};
		end else if (paddr == msps_pkg::OFF_MLO) begin
			nxt_rdata = mstate_ff[31:0];
		end else if (paddr == msps_pkg::OFF_MHI) begin
			nxt_rdata = {28'h000_0000, mstate_ff[35:32]};
		end else if (paddr == msps_pkg::OFF_IRQ) begin
			nxt_rdata = {31'h0000_0000, flag_ff};
		end else begin
			nxt_rdata = 32'h0000_0000;
		end
	end
	assign prdata = prdata_ff;

	// microsecond tick; slow timing runs on this enable
	wire us_tick = (us_cnt_ff == 7'h00);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			us_cnt_ff <= 7'h00;
		end else begin
			us_cnt_ff <= us_tick ? 7'(msps_pkg::US_CYC - 1) : us_cnt_ff - 7'h01;
		end
	end

	// sequencer timing and step control
	wire expire = (tmr_ff == 16'h0000);
	wire mtx_last = (si_ff == n_m - 3'h1) && (sj_ff == n_m - 3'h1);
	wire std_step = (st_ff == msps_pkg::ST_STD) && expire;
	wire mtx_step = (st_ff == msps_pkg::ST_MTX) && expire;
	wire scan_end = (std_step && (std_next == 5'h18)) ||
		(mtx_step && mtx_last && (std_first == 5'h18));
	msps_pkg::msps_state_e nxt_st;
	logic [15:0] nxt_tmr;
	always_comb begin
		nxt_st = st_ff;
		nxt_tmr = expire ? tmr_ff : tmr_ff - {15'h0000, us_tick};
		case (st_ff)
			msps_pkg::ST_IDLE: begin
				if (run) begin
					nxt_st = (n_m != 3'h0) ? msps_pkg::ST_MTX : msps_pkg::ST_STD;
					nxt_tmr = 16'(ACT_US);
				end
			end
			msps_pkg::ST_MTX: begin
				if (expire) begin
					nxt_tmr = 16'(ACT_US);
					if (mtx_last) begin
						nxt_st = msps_pkg::ST_STD;
					end
				end
			end
			msps_pkg::ST_STD: begin
				if (expire) begin
					nxt_tmr = 16'(ACT_US);
				end
			end
			msps_pkg::ST_GAP: begin
				if (expire) begin
					nxt_st = msps_pkg::ST_CLEAN;
					nxt_tmr = 16'(cfg_ff[msps_pkg::IDX_CLCFG][msps_pkg::CLCFG_DUR +: 8]);
				end
			end
			msps_pkg::ST_CLEAN: begin
				if (expire) begin
					nxt_st = msps_pkg::ST_WAIT;
					nxt_tmr = cont_mode ? 16'h0000 : 16'(POLL_US);
				end
			end
			msps_pkg::ST_WAIT: begin
				if (expire) begin
					nxt_st = msps_pkg::ST_IDLE;
				end
			end
			default: nxt_st = msps_pkg::ST_IDLE;
		endcase
		if (scan_end) begin
			nxt_st = clean_en ? msps_pkg::ST_GAP : msps_pkg::ST_WAIT;
			nxt_tmr = clean_en ? 16'(msps_pkg::CLEAN_STEP_DELAY_US) :
				(cont_mode ? 16'h0000 : 16'(POLL_US));
		end
		if (!run) begin
			nxt_st = msps_pkg::ST_IDLE;
		end
	end

	// step state; the matrix walks source fastest, then sink
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= msps_pkg::ST_IDLE;
			tmr_ff <= 16'h0000;
			si_ff <= 3'h0;
			sj_ff <= 3'h0;
			idx_ff <= 5'h00;
		end else begin
			st_ff <= nxt_st;
			tmr_ff <= nxt_tmr;
			if (st_ff == msps_pkg::ST_IDLE) begin
				si_ff <= 3'h0;
				sj_ff <= 3'h0;
				idx_ff <= std_first;
			end else if (mtx_step) begin
				sj_ff <= (sj_ff == n_m - 3'h1) ? 3'h0 : sj_ff + 3'h1;
				si_ff <= (sj_ff == n_m - 3'h1) ? si_ff + 3'h1 : si_ff;
			end else if (std_step) begin
				idx_ff <= std_next;
			end
		end
	end

	// sampling: matrix on the source side, standard by mode
	wire above_std = conv[idx_ff] ? (adc_s > lvl_for(idx_ff, cfg_ff[msps_pkg::IDX_LMAP][9:0],
		cfg_ff[msps_pkg::IDX_L2B][9:0], cfg_ff[msps_pkg::IDX_L3C][9:0],
		cfg_ff[msps_pkg::IDX_L9][9:0])) : sense_s[idx_ff];
	wire [5:0] mbit = 6'(si_ff * 3'h6) + {3'h0, sj_ff};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mnew_ff <= 36'h0_0000_0000;
		end else if (mtx_step) begin
			mnew_ff[mbit] <= sense_s[5'h0A + {2'h0, sj_ff}];
		end
	end

	// per-input filter, matrix inputs never tick it
	logic [23:0] filt;
	logic [2:0] base_code [24];
	logic [71:0] nxt_code;
	logic [23:0] nxt_on;
	genvar g;
	generate
		for (g = 0; g < 24; g++) begin : g_in
			wire tick_g = std_step && (idx_ff == 5'(g));
			msps_filter u_filt (
				.clk(pclk),
				.rst_n(presetn),
				.tick(tick_g),
				.smp(above_std),
				.depth(deb),
				.state_ff(filt[g])
			);
			wire [31:0] wcw = cfg_ff[msps_pkg::IDX_WCA + 4'(g / 10)];
			assign base_code[g] = wcw[(g % 10) * 3 +: 3];
			wire hi_set = (base_code[g] == msps_pkg::CUR_10MA) ||
				(base_code[g] == msps_pkg::CUR_15MA);
			wire tw_cut = tw_s && !(role[g] ? ctrl[msps_pkg::CTRL_TWOFF_SRC] :
				ctrl[msps_pkg::CTRL_TWOFF_SNK]);
			wire as_cut = cont_mode && !filt[g] && !(role[g] ? wcb[msps_pkg::WCB_ASOFF_SRC] :
				wcb[msps_pkg::WCB_ASOFF_SNK]);
			assign nxt_code[g*3 +: 3] = (st_ff == msps_pkg::ST_CLEAN) ?
				cfg_ff[msps_pkg::IDX_CLCFG][2:0] :
				((hi_set && (tw_cut || as_cut)) ? msps_pkg::CUR_2MA : base_code[g]);
		end
	endgenerate

	// wetting enables: one step at a time, all enabled at once when continuous, enabled and unmasked when cleaning
	always_comb begin
		nxt_on = 24'h00_0000;
		case (st_ff)
			msps_pkg::ST_MTX: begin
				nxt_on[5'h04 + {2'h0, si_ff}] = 1'b1;
				nxt_on[5'h0A + {2'h0, sj_ff}] = 1'b1;
			end
			msps_pkg::ST_STD: nxt_on[idx_ff] = (idx_ff != 5'h18);
			msps_pkg::ST_CLEAN: nxt_on = eff_en & ~cfg_ff[msps_pkg::IDX_CLMSK][23:0];
			default: nxt_on = 24'h00_0000;
		endcase
		if (cont_mode && run && (st_ff != msps_pkg::ST_CLEAN)) begin
			nxt_on = eff_en;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wet_on_ff <= 24'h00_0000;
			wet_code_ff <= 72'h00_0000_0000_0000_0000;
		end else begin
			wet_on_ff <= nxt_on;
			wet_code_ff <= nxt_code;
		end
	end

	// change detection against the stored baselines
	wire [23:0] new_stat = (filt & std_mask) | (status_ff & ~std_mask);
	wire [23:0] irqa = cfg_ff[msps_pkg::IDX_IRQA][23:0];
	wire [23:0] irqb = cfg_ff[msps_pkg::IDX_IRQB][23:0];
	logic [35:0] m_ra;
	logic [35:0] m_fb;
	always_comb begin
		for (int k = 0; k < 36; k++) begin
			m_ra[k] = irqa[10 + (k % 6)];
			m_fb[k] = irqb[10 + (k % 6)];
		end
	end
	wire std_chg = |(((new_stat & ~status_ff & irqa) | (~new_stat & status_ff & irqb)) & std_mask);
	wire mtx_chg = |((mnew_ff & ~mstate_ff & m_ra) | (~mnew_ff & mstate_ff & m_fb));
	wire flag_set = done_ff && (first_ff || std_chg || (mtx_chg && (n_m != 3'h0)));

	// cycle end bookkeeping; a set in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_ff <= 1'b0;
			first_ff <= 1'b0;
			flag_ff <= 1'b0;
			status_ff <= 24'h00_0000;
			mstate_ff <= 36'h0_0000_0000;
		end else begin
			done_ff <= scan_end; // filters settle one cycle after the last tick
			flag_ff <= flag_set || (flag_ff && !irq_rd);
			if (trig_wr) begin
				first_ff <= 1'b1;
			end else if (done_ff) begin
				first_ff <= 1'b0;
			end
			if (done_ff) begin
				status_ff <= new_stat;
				if (n_m != 3'h0) begin
					mstate_ff <= mnew_ff;
				end
			end
		end
	end

	assign wet_on = wet_on_ff;
	assign wet_code = wet_code_ff;
	assign adc_sel = idx_ff;
	assign cmp_level = cfg_ff[msps_pkg::IDX_LCMP][9:0];
	assign irq_n = !flag_ff;
	assign switch_change_flag = flag_ff;

	AST_FIRST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
		done_ff && first_ff |=> flag_ff && !irq_n) else $error("first cycle gave no irq");
	AST_READ_CLR: assert property (@(posedge pclk) disable iff (!presetn)
		irq_rd && !flag_set |=> irq_n) else $error("irq status read did not clear");
	AST_MTX_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(st_ff == msps_pkg::ST_STD) && (n_m != 3'h0) |-> $past(st_ff) == msps_pkg::ST_MTX)
		else $error("standard step before matrix");
	AST_MTX_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
		st_ff == msps_pkg::ST_MTX |=> wet_on_ff[5'h04 + {2'h0, $past(si_ff)}])
		else $error("matrix sink not driven");
	AST_CLEAN_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff == msps_pkg::ST_CLEAN) && !done_ff |=> !$rose(flag_ff))
		else $error("cleaning raised irq");
	AST_TW_CUT: assert property (@(posedge pclk) disable iff (!presetn)
		tw_s && !(role[1] ? ctrl[msps_pkg::CTRL_TWOFF_SRC] : ctrl[msps_pkg::CTRL_TWOFF_SNK]) &&
		(base_code[1] == msps_pkg::CUR_15MA) && (st_ff != msps_pkg::ST_CLEAN)
		|=> wet_code_ff[5:3] == msps_pkg::CUR_2MA) else $error("thermal cut missing");
	AST_NO_CONT: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff == msps_pkg::ST_STD) && (n_m != 3'h0) |=> $onehot0(wet_on_ff))
		else $error("continuous drive in matrix mode");
	AST_CLEAN_START: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff == msps_pkg::ST_GAP) && expire && run ##1 (st_ff == msps_pkg::ST_CLEAN)
		|=> wet_on_ff == $past(eff_en & ~cfg_ff[msps_pkg::IDX_CLMSK][23:0]))
		else $error("cleaning step wrong");
endmodule // msps_core

// ==== rtl/msps_filter.sv ====
// per-input detection filter, also steers wetting auto-scaling
`timescale 1ns/1ns
module msps_filter (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic smp,
	input wire logic [1:0] depth,
	output logic state_ff
);
	logic [1:0] cnt_ff;

	// state follows a new value after depth+1 equal samples in a row
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= 1'b1; // open: a reset must not look like a closed contact
			cnt_ff <= 2'h0;
		end else if (tick) begin
			if (smp == state_ff) begin
				cnt_ff <= 2'h0;
			end else if (cnt_ff == depth) begin
				state_ff <= smp;
				cnt_ff <= 2'h0;
			end else begin
				cnt_ff <= cnt_ff + 2'h1;
			end
		end
	end
endmodule // msps_filter

// ==== rtl/msps_sync.sv ====
// two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ns
module msps_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			q <= '0;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule // msps_sync

// ==== shared/msps_pkg.sv ====
// shared constants and types of the matrix switch poll sequencer
package msps_pkg;
	// configuration register indexes, byte address is four times the index
	localparam logic [3:0] IDX_CTRL = 4'h0;
	localparam logic [3:0] IDX_MODE = 4'h1;
	localparam logic [3:0] IDX_EN = 4'h2;
	localparam logic [3:0] IDX_ROLE = 4'h3;
	localparam logic [3:0] IDX_WCA = 4'h4;
	localparam logic [3:0] IDX_WCB = 4'h5;
	localparam logic [3:0] IDX_WCC = 4'h6;
	localparam logic [3:0] IDX_CLCFG = 4'h7;
	localparam logic [3:0] IDX_CLMSK = 4'h8;
	localparam logic [3:0] IDX_IRQA = 4'h9;
	localparam logic [3:0] IDX_IRQB = 4'hA;
	localparam logic [3:0] IDX_LCMP = 4'hB;
	localparam logic [3:0] IDX_LMAP = 4'hC;
	localparam logic [3:0] IDX_L2B = 4'hD;
	localparam logic [3:0] IDX_L3C = 4'hE;
	localparam logic [3:0] IDX_L9 = 4'hF;
	// read-only status registers
	localparam logic [7:0] OFF_STAT = 8'h40;
	localparam logic [7:0] OFF_MLO = 8'h44;
	localparam logic [7:0] OFF_MHI = 8'h48;
	localparam logic [7:0] OFF_IRQ = 8'h4C;
	// control word, wetting and cleaning register fields, reset value
	localparam int CTRL_TRIG = 0;
	localparam int CTRL_CONT = 1;
	localparam int CTRL_MTX = 2;
	localparam int CTRL_DEB = 4;
	localparam int CTRL_CLEAN = 6;
	localparam int CTRL_TWOFF_SRC = 7;
	localparam int CTRL_TWOFF_SNK = 8;
	localparam int WCB_ASOFF_SRC = 30;
	localparam int WCB_ASOFF_SNK = 31;
	localparam int CLCFG_DUR = 8;
	localparam logic [31:0] RST_CFG = 32'h0000_0000;
	// wetting current codes
	localparam logic [2:0] CUR_2MA = 3'h2;
	localparam logic [2:0] CUR_10MA = 3'h4;
	localparam logic [2:0] CUR_15MA = 3'h5;
	// matrix select codes
	localparam logic [1:0] MTX_NONE = 2'h0;
	localparam logic [1:0] MTX_4 = 2'h1;
	localparam logic [1:0] MTX_5 = 2'h2;
	// timing
	localparam int CLK_NS = 10;
	localparam int US_NS = 1000;
	localparam int US_CYC = US_NS / CLK_NS;
	localparam int ACT_US_DEF = 64;
	localparam int POLL_US_DEF = 2000;
	localparam int CLEAN_STEP_DELAY_US = 8;
	typedef enum logic [2:0] {ST_IDLE, ST_MTX, ST_STD, ST_GAP, ST_CLEAN, ST_WAIT} msps_state_e;
endpackage
